//--- pkg/seq_select_pkg.sv
// Register map, field layout and helpers of the step input selector
package seq_select_pkg;

    // Bus geometry
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int NUM_STEPS = 8;
    localparam int STEP_W    = 3;
    localparam int CHAN_W    = 2;
    localparam int CHAN_NUM  = 4;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] SEQ0_SEL_OFFSET = 12'h040;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 12'h048;

    // Selector register layout and reset
    localparam int FIELD_PITCH = 4;
    localparam int STEP_CHANNEL_LSB [NUM_STEPS] =
        '{0, 4, 8, 12, 16, 20, 24, 28};
    localparam logic [DATA_W-1:0] SEQ0_SEL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SEQ0_SEL_MASK  = 32'h3333_3333;

    // Status register layout
    localparam int STAT_STEP_LSB   = 0;
    localparam int STAT_CHAN_LSB   = 4;
    localparam int STAT_ACTIVE_BIT = 8;

    // Field of a given step, taken as a binary channel index
    function automatic logic [CHAN_W-1:0] field_of(
        input logic [DATA_W-1:0] word,
        input logic [STEP_W-1:0] step
    );
        logic [DATA_W-1:0] shifted;
        shifted  = word >> (step * FIELD_PITCH);
        field_of = shifted[CHAN_W-1:0];
    endfunction : field_of

    // Binary channel index to one-hot pin enable
    function automatic logic [CHAN_NUM-1:0] onehot_of(
        input logic [CHAN_W-1:0] chan
    );
        onehot_of = CHAN_NUM'(1) << chan;
    endfunction : onehot_of

endpackage : seq_select_pkg

//--- pkg/step_sel_if.sv
// Carrier between the register file and the channel selector
`timescale 1ns/1ps
interface step_sel_if
    import seq_select_pkg::*;
();
    logic [DATA_W-1:0]   sel_word;
    logic [STEP_W-1:0]   step;
    logic                step_active;
    logic                ce;
    logic                rst;
    logic [CHAN_W-1:0]   channel;
    logic [CHAN_NUM-1:0] pin_enable;

    modport reg_side (
        output sel_word, step, step_active, ce, rst,
        input  channel, pin_enable
    );
    modport mux_side (
        input  sel_word, step, step_active, ce, rst,
        output channel, pin_enable
    );
endinterface : step_sel_if

//--- hdl/channel_select.sv
// Picks the selector field of the running step for the input multiplexer
`timescale 1ns/1ps
module channel_select
    import seq_select_pkg::*;
#(
    parameter int STEPS = NUM_STEPS
) (
    // Clock
    input wire logic    core_clk,
    // Register side
    step_sel_if.mux_side sel
);

    generate
        if (STEPS < 1 || STEPS > NUM_STEPS) begin : g_bad_steps
            $error("channel_select: STEPS out of range");
        end
    endgenerate

    wire logic [CHAN_W-1:0] picked;
    wire logic              take;

    assign picked = field_of(sel.sel_word, sel.step);
    assign take   = sel.ce && sel.step_active
                    && (int'(sel.step) < STEPS);

    // Output held between steps so the mux stays settled
    always_ff @(posedge core_clk) begin
        if (sel.rst) begin
            sel.channel    <= '0;
            sel.pin_enable <= CHAN_NUM'(1);
        end else if (take) begin
            sel.channel    <= picked;
            sel.pin_enable <= onehot_of(picked);
        end
    end

endmodule : channel_select

//--- hdl/seq0_input_select.sv
// APB register and step-indexed input choice for the first sequencer
//
// Contract
// [R01] Step one converts the input chosen by bits 1:0.
// [R02] Step two converts the input chosen by bits 5:4.
// [R03] Step three converts the input chosen by bits 9:8.
// [R04] Step four converts the input chosen by bits 13:12.
// [R05] Step five converts the input chosen by bits 17:16.
// [R06] Step six converts the input chosen by bits 21:20.
// [R07] Step seven converts the input chosen by bits 25:24.
// [R08] Step eight converts the input chosen by bits 29:28.
// [R09] Each field is a binary pin index, so one selects input one.
// [R10] The bit pairs between fields are read-only zero.
// [R11] The 32-bit register serves sequencer zero and resets to zero.
// [R12] The mux sees the field of the current step, updated as it moves.
`timescale 1ns/1ps
module seq0_input_select
    import seq_select_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Sequencer step
    input  wire logic [STEP_W-1:0]   step_index,
    input  wire logic                step_active,
    // Converter input multiplexer
    output logic      [CHAN_W-1:0]   channel_sel,
    output logic      [CHAN_NUM-1:0] channel_pin_en
);

    logic [DATA_W-1:0] seq0_input_select;

    step_sel_if sel ();

    // Address decode
    wire logic hit_sel;
    wire logic hit_stat;
    wire logic mapped;
    wire logic setup;
    wire logic access;
    wire logic wr_sel;

    assign hit_sel  = (paddr == SEQ0_SEL_OFFSET);
    assign hit_stat = (paddr == STATUS_OFFSET);
    assign mapped   = hit_sel || hit_stat;
    assign setup    = psel && !penable && clk_en;
    assign access   = psel && penable && clk_en;
    assign wr_sel   = access && pwrite && hit_sel;

    // Frozen enable stretches the access instead of losing it
    assign pready  = clk_en;
    assign pslverr = psel && penable && !mapped;

    // Byte lanes merged, reserved pairs forced to zero
    wire logic [DATA_W-1:0] lane_mask;
    wire logic [DATA_W-1:0] next_sel;

    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                        {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign next_sel  = ((pwdata & lane_mask)
                       | (seq0_input_select & ~lane_mask))
                       & SEQ0_SEL_MASK;                           // [R10]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq0_input_select <= SEQ0_SEL_RESET;                  // [R11]
        end else if (wr_sel) begin
            seq0_input_select <= next_sel;
        end
    end

    // Status word shows the live step and the channel on the mux
    wire logic [DATA_W-1:0] status_word;
    wire logic [DATA_W-1:0] read_mux;

    assign status_word = (DATA_W'(step_index) << STAT_STEP_LSB)
                       | (DATA_W'(channel_sel) << STAT_CHAN_LSB)
                       | (DATA_W'(step_active) << STAT_ACTIVE_BIT);
    assign read_mux = hit_sel  ? seq0_input_select :
                      hit_stat ? status_word : '0;

    // Read data captured in setup so prdata is a flop in access
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= pwrite ? '0 : read_mux;
        end
    end

    // Channel selection
    assign sel.sel_word    = seq0_input_select;
    assign sel.step        = step_index;
    assign sel.step_active = step_active;
    assign sel.ce          = clk_en;
    assign sel.rst         = rst;

    channel_select #(
        .STEPS (NUM_STEPS)
    ) u_channel_select (
        .core_clk (core_clk),
        .sel      (sel.mux_side)
    );                                                            // [R12]

    assign channel_sel    = sel.channel;                          // [R09]
    assign channel_pin_en = sel.pin_enable;

    // Checks

    sequence step_taken(int k);
        clk_en && step_active && (step_index == STEP_W'(k));
    endsequence

    property step_routes(int k);
        @(posedge core_clk) disable iff (rst)
        step_taken(k) |=> channel_sel ==
            $past(seq0_input_select[STEP_CHANNEL_LSB[k] +: CHAN_W]);
    endproperty

    step0_route_a: assert property (step_routes(0))  // [R01]
        else $error("step one channel mismatch");
    step1_route_a: assert property (step_routes(1))  // [R02]
        else $error("step two channel mismatch");
    step2_route_a: assert property (step_routes(2))  // [R03]
        else $error("step three channel mismatch");
    step3_route_a: assert property (step_routes(3))  // [R04]
        else $error("step four channel mismatch");
    step4_route_a: assert property (step_routes(4))  // [R05]
        else $error("step five channel mismatch");
    step5_route_a: assert property (step_routes(5))  // [R06]
        else $error("step six channel mismatch");
    step6_route_a: assert property (step_routes(6))  // [R07]
        else $error("step seven channel mismatch");
    step7_route_a: assert property (step_routes(7))  // [R08]
        else $error("step eight channel mismatch");

    pin_binary_a: assert property (  // [R09]
        @(posedge core_clk) disable iff (rst)
        channel_pin_en == onehot_of(channel_sel))
        else $error("pin enable does not match channel index");

    reserved_zero_a: assert property (  // [R10]
        @(posedge core_clk) disable iff (rst)
        (seq0_input_select & ~SEQ0_SEL_MASK) == '0)
        else $error("reserved selector bits not zero");

    reset_clear_a: assert property (  // [R11]
        @(posedge core_clk)
        rst |=> seq0_input_select == SEQ0_SEL_RESET
                && channel_sel == '0)
        else $error("selector not cleared by reset");

    sequence step_idle;
        !step_active || !clk_en;
    endsequence

    hold_between_a: assert property (  // [R12]
        @(posedge core_clk) disable iff (rst)
        step_idle |=> $stable(channel_sel))
        else $error("channel moved without a step");

    sequence sel_written;
        wr_sel ##1 clk_en && step_active;
    endsequence

    write_reaches_mux_a: assert property (  // [R12]
        @(posedge core_clk) disable iff (rst)
        sel_written |=> channel_sel ==
            field_of($past(next_sel, 2), $past(step_index)))
        else $error("written field not seen by the mux");

    read_back_a: assert property (  // [R10]
        @(posedge core_clk) disable iff (rst)
        setup && !pwrite && hit_sel |=>
            prdata == ($past(seq0_input_select) & SEQ0_SEL_MASK))
        else $error("read data differs from selector register");

    unmapped_err_a: assert property (
        @(posedge core_clk) disable iff (rst)
        psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not flagged");

    frozen_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !clk_en |=> $stable(seq0_input_select) && $stable(channel_sel))
        else $error("state changed while clock enable was low");

endmodule : seq0_input_select

//--- verif/tb_top.sv
// Self-checking bench for the sequencer zero input selector
`timescale 1ns/1ps
module tb_top
    import seq_select_pkg::*;
();
    // Clock, reset, enable
    logic                core_clk    = 1'b0;
    logic                rst         = 1'b1;
    logic                clk_en      = 1'b1;
    // APB
    logic                psel        = 1'b0;
    logic                penable     = 1'b0;
    logic                pwrite      = 1'b0;
    logic [ADDR_W-1:0]   paddr       = '0;
    logic [DATA_W-1:0]   pwdata      = '0;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    // Sequencer and mux
    logic [STEP_W-1:0]   step_index  = '0;
    logic                step_active = 1'b0;
    logic [CHAN_W-1:0]   channel_sel;
    logic [CHAN_NUM-1:0] channel_pin_en;
    int                  errors      = 0;
    int                  compares    = 0;
    int                  cycles      = 0;

    seq0_input_select u_dut (
        .core_clk       (core_clk),
        .rst            (rst),
        .clk_en         (clk_en),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .pstrb          (4'hF),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .step_index     (step_index),
        .step_active    (step_active),
        .channel_sel    (channel_sel),
        .channel_pin_en (channel_pin_en)
    );

    always #10 core_clk = ~core_clk;

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One transfer; an idle edge after it keeps drives one per time step
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic reset_values();
        logic [DATA_W-1:0] rd;
        logic              err;
        chk("channel_sel", 32'(channel_sel), 32'h0);
        chk("pin_en", 32'(channel_pin_en), 32'h1);
        apb(1'b0, SEQ0_SEL_OFFSET, '0, rd, err);
        chk("reset word", rd, 32'h0000_0000);
        chk("reset err", 32'(err), 32'h0);
    endtask : reset_values

    // Reserved pairs must read zero whatever was written
    task automatic reserved_bits();
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b1, SEQ0_SEL_OFFSET, 32'hFFFF_FFFF, rd, err);
        apb(1'b0, SEQ0_SEL_OFFSET, '0, rd, err);
        chk("all ones", rd, 32'h3333_3333);
        apb(1'b1, SEQ0_SEL_OFFSET, 32'hFEDC_BA98, rd, err);
        apb(1'b0, SEQ0_SEL_OFFSET, '0, rd, err);
        chk("pattern", rd, 32'h3210_3210);
    endtask : reserved_bits

    task automatic unmapped();
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b1, 12'h0FC, 32'h0000_0001, rd, err);
        chk("unmapped err", 32'(err), 32'h1);
        apb(1'b0, SEQ0_SEL_OFFSET, '0, rd, err);
        chk("kept word", rd, 32'h3210_3210);
    endtask : unmapped

    // Fields of 0x32103210 give channels 0,1,2,3 twice over
    task automatic step_walk();
        logic [CHAN_W-1:0] ch;
        for (int k = 0; k < 8; k++) begin
            ch = CHAN_W'(k % 4);
            step_index  <= STEP_W'(k);
            step_active <= 1'b1;
            @(posedge core_clk);
            @(negedge core_clk);
            chk("step chan", 32'(channel_sel), 32'(ch));
            chk("step pin", 32'(channel_pin_en), 32'(4'h1 << ch));
            @(posedge core_clk);
        end
    endtask : step_walk

    // Disabled clock or idle sequencer must hold the mux choice
    task automatic freeze();
        clk_en     <= 1'b0;
        step_index <= 3'd1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("frozen chan", 32'(channel_sel), 32'h3);
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        chk("resumed chan", 32'(channel_sel), 32'h1);
        @(posedge core_clk);
        step_active <= 1'b0;
        step_index  <= 3'd3;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("idle chan", 32'(channel_sel), 32'h1);
        @(posedge core_clk);
    endtask : freeze

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        reset_values();
        reserved_bits();
        unmapped();
        step_walk();
        freeze();
        test_done();
    end
endmodule : tb_top
